// ===== hw/ssl_sequencer.sv
// supply sequencing timers, limit registers and fast supervisor status
`timescale 1ns/1ps
`default_nettype none

module ssl_sequencer import ssl_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic share_clk_i,
  input wire ssl_reg_req_s reg_req_i,
  output logic [15:0] reg_rdata_o,
  output logic reg_ack_o,
  input wire logic [NUM_CH-1:0] channel_on_request_pin_i,
  input wire ssl_fast_sup_s [NUM_CH-1:0] fast_sup_i,
  input wire logic [15:0] input_sense_pin_i,
  input wire logic [15:0] die_temp_i,
  output logic [NUM_CH-1:0] converter_enable_o,
  output logic [NUM_CH-1:0] dac_connect_o,
  output logic host_alert_line_n_o,
  output logic host_alert_line_oe_o,
  output logic share_present_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [8:0] share_div;
  logic share_tog;
  logic [2:0] share_sync;
  logic share_tick;
  logic [11:0] loss_cnt;
  logic [8:0] int_cnt;
  logic int_tick;
  logic timer_tick;
  logic [8:0] smp_cnt;
  logic sample;
  logic [NUM_CH-1:0] on_meta;
  logic [NUM_CH-1:0] on_sync;
  ssl_fast_sup_s [NUM_CH-1:0] sup_meta;
  ssl_fast_sup_s [NUM_CH-1:0] sup_sync;
  logic [15:0] paged_q [NUM_CH][PAGED_N];
  logic [15:0] glob_q [GLOB_N];
  logic [TICK_W-1:0] eff_q [NUM_CH][TIMER_N];
  logic [15:0] op_q [NUM_CH];
  logic [15:0] cfg_q [NUM_CH];
  logic [7:0] st_vout [NUM_CH];
  logic [7:0] st_vin;
  logic [7:0] st_temp;
  logic [NUM_CH-1:0] any_ov;
  logic [NUM_CH-1:0] any_uv;
  logic [NUM_CH-1:0] any_ton;
  logic vin_good;
  logic paged_hit;
  logic glob_hit;
  logic [7:0] p_idx;
  logic [7:0] g_idx;
  logic clear;
  logic [15:0] status_word;
  logic [15:0] rd_mux;
  logic signed [47:0] vin_fix;
  logic signed [47:0] tmp_fix;
  logic [7:0] vin_set;
  logic [7:0] temp_set;

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // linear-11 milliseconds to 10us ticks, clamped and rounded
  function automatic logic [TICK_W-1:0] to_ticks(input logic [15:0] raw, input logic long_lim);
    logic signed [4:0] ex;
    logic [4:0] sh;
    logic [39:0] v;
    logic [39:0] lim;
    ex = raw[15:11];
    sh = 5'(-ex);
    lim = long_lim ? 40'(TON_LIMIT_TICKS) : 40'(RISE_LIMIT_TICKS); // R14 R16
    v = 40'(raw[9:0]) * 40'(TICKS_PER_MS);
    if (raw[10]) begin
      v = '0;
    end else if (!ex[4]) begin
      v = v << ex[3:0];
    end else begin
      v = (v + (40'h1 << (sh - 5'h1))) >> sh; // R15 R16
    end
    if (v > lim) begin
      v = lim; // R14 R16
    end
    if (long_lim && v > 40'(RISE_LIMIT_TICKS)) begin
      v = ((v + 40'(COARSE_TICKS / 2)) / 40'(COARSE_TICKS)) * 40'(COARSE_TICKS); // R15
    end
    return v[TICK_W-1:0];
  endfunction : to_ticks

  // linear-11 to a common fixed point so that any two exponents compare
  function automatic logic signed [47:0] l11_fix(input logic [15:0] raw);
    logic signed [47:0] m;
    logic [5:0] s;
    m = {{37{raw[10]}}, raw[10:0]};
    s = {raw[15], raw[15:11]} + 6'h10;
    return m <<< s;
  endfunction : l11_fix

  ////////////////////////////////////////////////////////////////////////////
  // timebase: share clock domain and its crossing

  // share domain only divides; a 10us event crosses as a toggle
  always_ff @(posedge share_clk_i or posedge rst_i) begin
    if (rst_i) begin
      share_div <= 9'h000;
      share_tog <= 1'b0;
    end else if (share_div == 9'(SHARE_TICK_CYC - 1)) begin
      share_div <= 9'h000;
      share_tog <= ~share_tog;
    end else begin
      share_div <= share_div + 9'h001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      share_sync <= 3'h0;
    end else begin
      share_sync <= {share_sync[1:0], share_tog};
    end
  end

  assign share_tick = share_sync[2] ^ share_sync[1];

  // timebase counts as lost when no tick arrives for three tick periods
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      loss_cnt <= 12'h000;
      share_present_o <= 1'b0;
    end else if (share_tick) begin
      loss_cnt <= 12'h000;
      share_present_o <= 1'b1;
    end else if (loss_cnt == 12'(SHARE_LOSS_CYC)) begin
      share_present_o <= 1'b0;
    end else begin
      loss_cnt <= loss_cnt + 12'h001;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      int_cnt <= 9'h000;
      smp_cnt <= 9'h000;
    end else begin
      int_cnt <= int_tick ? 9'h000 : int_cnt + 9'h001;
      smp_cnt <= sample ? 9'h000 : smp_cnt + 9'h001;
    end
  end

  assign int_tick = int_cnt == 9'(INT_TICK_CYC - 1);
  assign sample = smp_cnt == 9'(SAMPLE_CYC - 1);
  assign timer_tick = share_present_o ? share_tick : int_tick; // R9

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_meta <= '0;
      on_sync <= '0;
      sup_meta <= '0;
      sup_sync <= '0;
    end else begin
      on_meta <= channel_on_request_pin_i;
      on_sync <= on_meta;
      sup_meta <= fast_sup_i;
      sup_sync <= sup_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes

  assign p_idx = reg_req_i.cmd - CMD_PAGED_BASE;
  assign g_idx = reg_req_i.cmd - CMD_GLOB_BASE;
  assign paged_hit = reg_req_i.cmd >= CMD_PAGED_BASE && p_idx < 8'(PAGED_N);
  assign glob_hit = reg_req_i.cmd >= CMD_GLOB_BASE && g_idx < 8'(GLOB_N);
  assign clear = reg_req_i.wr && reg_req_i.cmd == CMD_CLEAR;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        for (int i = 0; i < PAGED_N; i++) begin
          paged_q[c][i] <= LIMIT_RESET;
        end
        for (int t = 0; t < TIMER_N; t++) begin
          eff_q[c][t] <= '0;
        end
        op_q[c] <= OPERATION_RESET;
        cfg_q[c] <= CHAN_CFG_RESET;
      end
      for (int g = 0; g < GLOB_N; g++) begin
        glob_q[g] <= LIMIT_RESET;
      end
    end else if (reg_req_i.wr) begin
      if (paged_hit) begin
        paged_q[reg_req_i.page][p_idx[3:0]] <= reg_req_i.wdata; // R1 R6 R17
        if (p_idx >= 8'(IDX_TON_DELAY)) begin
          eff_q[reg_req_i.page][2'(p_idx - 8'(IDX_TON_DELAY))] <=
            to_ticks(reg_req_i.wdata,
                     p_idx == 8'(IDX_TON_DELAY) || p_idx == 8'(IDX_TOFF_DELAY)); // R14 R15 R16
        end
      end
      if (glob_hit) begin
        glob_q[g_idx[3:0]] <= reg_req_i.wdata; // R3 R5
      end
      if (reg_req_i.cmd == CMD_OPERATION) begin
        op_q[reg_req_i.page] <= reg_req_i.wdata;
      end
      if (reg_req_i.cmd == CMD_CHAN_CFG) begin
        cfg_q[reg_req_i.page] <= reg_req_i.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register reads

  always_comb begin
    rd_mux = 16'h0000;
    if (paged_hit) begin
      rd_mux = paged_q[reg_req_i.page][p_idx[3:0]]; // R17
    end else if (glob_hit) begin
      rd_mux = glob_q[g_idx[3:0]];
    end else begin
      case (reg_req_i.cmd)
        CMD_OPERATION: rd_mux = op_q[reg_req_i.page];
        CMD_CHAN_CFG: rd_mux = cfg_q[reg_req_i.page];
        CMD_STATUS_VOUT: rd_mux = {8'h00, st_vout[reg_req_i.page]};
        CMD_OUT_MODE: rd_mux = OUT_MODE_VALUE; // R2
        CMD_STATUS_WORD: rd_mux = status_word;
        CMD_STATUS_VIN: rd_mux = {8'h00, st_vin};
        CMD_STATUS_TEMP: rd_mux = {8'h00, st_temp};
        default: rd_mux = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 16'h0000;
      reg_ack_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_req_i.rd ? rd_mux : 16'h0000;
      reg_ack_o <= reg_req_i.rd | reg_req_i.wr;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input and temperature supervision

  assign vin_fix = l11_fix(input_sense_pin_i);
  assign tmp_fix = l11_fix(die_temp_i);

  always_comb begin
    vin_set = 8'h00;
    temp_set = 8'h00;
    vin_set[ST_OV_FAULT] = vin_fix > l11_fix(glob_q[IDX_VIN_OV_F]); // R4
    vin_set[ST_OV_WARN] = vin_fix > l11_fix(glob_q[IDX_VIN_OV_W]); // R4
    vin_set[ST_UV_WARN] = vin_fix < l11_fix(glob_q[IDX_VIN_UV_W]); // R4
    vin_set[ST_UV_FAULT] = vin_fix < l11_fix(glob_q[IDX_VIN_UV_F]); // R4
    temp_set[ST_OV_FAULT] = tmp_fix > l11_fix(glob_q[IDX_OT_F]); // R5
    temp_set[ST_OV_WARN] = tmp_fix > l11_fix(glob_q[IDX_OT_W]); // R5
    temp_set[ST_UV_WARN] = tmp_fix < l11_fix(glob_q[IDX_UT_W]); // R5
    temp_set[ST_UV_FAULT] = tmp_fix < l11_fix(glob_q[IDX_UT_F]); // R5
  end

  // start/stop hysteresis gates every channel's on request
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      vin_good <= 1'b0;
    end else if (vin_fix >= l11_fix(glob_q[IDX_VIN_ON])) begin
      vin_good <= 1'b1; // R4
    end else if (vin_fix < l11_fix(glob_q[IDX_VIN_OFF])) begin
      vin_good <= 1'b0; // R4
    end
  end

  // sticky bits: a set in the clearing cycle survives
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_vin <= 8'h00;
      st_temp <= 8'h00;
    end else begin
      st_vin <= (clear ? 8'h00 : st_vin) | vin_set;
      st_temp <= (clear ? 8'h00 : st_temp) | temp_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel sequencer and fast supervisor

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    localparam bit ODD = (ch % 2) == 1;
    ssl_ch_state_e state;
    ssl_fast_sup_s sup;
    logic [TICK_W-1:0] cnt;
    logic [TICK_W-1:0] rcnt;
    logic [2:0] ovg;
    logic [2:0] uvg;
    logic [2:0] deg;
    logic uv_unmask;
    logic on_req;
    logic ton_max_evt;
    logic ov_evt;
    logic uv_evt;
    logic [7:0] set;

    assign sup = (ODD && cfg_q[ch][CFG_HIRES_BIT]) ? '0 : sup_sync[ch]; // R20
    assign on_req = on_sync[ch] && op_q[ch][OP_ON_BIT] && vin_good;
    assign deg = cfg_q[ch][CFG_DEGLITCH_LSB +: 3];
    assign ton_max_evt = state == CH_RAMP && eff_q[ch][TM_MAX] != '0 &&
                         rcnt >= eff_q[ch][TM_MAX] && sup.uv_fault; // R10 R11 R12

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        state <= CH_OFF;
        cnt <= '0;
        converter_enable_o[ch] <= 1'b0;
        uv_unmask <= 1'b0;
      end else begin
        case (state)
          CH_OFF: begin
            cnt <= '0;
            if (on_req) begin
              state <= CH_ON_WAIT;
            end
          end
          CH_ON_WAIT: begin
            if (!on_req) begin
              state <= CH_OFF;
            end else if (cnt >= eff_q[ch][TM_ON]) begin
              converter_enable_o[ch] <= 1'b1; // R7
              state <= CH_RAMP;
            end else if (share_tick) begin
              cnt <= cnt + 1'b1; // R7
            end
          end
          CH_RAMP: begin
            cnt <= '0;
            if (!on_req) begin
              state <= CH_OFF_WAIT;
            end else if (!sup.uv_fault || ton_max_evt) begin
              uv_unmask <= 1'b1; // R11
              state <= CH_ON;
            end
          end
          CH_ON: begin
            cnt <= '0;
            if (!on_req) begin
              state <= CH_OFF_WAIT;
            end
          end
          CH_OFF_WAIT: begin
            if (on_req) begin
              state <= uv_unmask ? CH_ON : CH_RAMP;
            end else if (cnt >= eff_q[ch][TM_OFF]) begin
              converter_enable_o[ch] <= 1'b0; // R13
              uv_unmask <= 1'b0;
              state <= CH_OFF;
            end else if (timer_tick) begin
              cnt <= cnt + 1'b1; // R9 R13
            end
          end
          default: state <= CH_OFF;
        endcase
      end
    end

    // ramp counter saturates so a late trim connect is still caught
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        rcnt <= '0;
        dac_connect_o[ch] <= 1'b0;
      end else begin
        if (!converter_enable_o[ch]) begin
          rcnt <= '0;
        end else if (timer_tick && rcnt != '1) begin
          rcnt <= rcnt + 1'b1; // R9
        end
        dac_connect_o[ch] <= converter_enable_o[ch] &&
                             cfg_q[ch][CFG_DAC_LSB +: 2] == 2'h0 &&
                             rcnt >= eff_q[ch][TM_RISE]; // R8
      end
    end

    // deglitch counts supervisor samples while the fault persists
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        ovg <= 3'h0;
        uvg <= 3'h0;
      end else begin
        if (!sup.ov_fault) begin
          ovg <= 3'h0;
        end else if (sample && ovg != deg) begin
          ovg <= ovg + 3'h1; // R19
        end
        if (!(sup.uv_fault && uv_unmask)) begin
          uvg <= 3'h0;
        end else if (sample && uvg != deg) begin
          uvg <= uvg + 3'h1; // R19
        end
      end
    end

    assign ov_evt = sup.ov_fault && ovg == deg; // R19
    assign uv_evt = sup.uv_fault && uv_unmask && uvg == deg; // R11 R19

    always_comb begin
      set = 8'h00;
      set[ST_OV_FAULT] = ov_evt;
      set[ST_OV_WARN] = sup.ov_warn;
      set[ST_UV_WARN] = sup.uv_warn && uv_unmask;
      set[ST_UV_FAULT] = uv_evt;
      set[ST_TON_MAX] = ton_max_evt; // R11
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
        st_vout[ch] <= 8'h00;
      end else begin
        st_vout[ch] <= (clear ? 8'h00 : st_vout[ch]) | set; // R18
      end
    end

    assign any_ov[ch] = st_vout[ch][ST_OV_FAULT] | st_vout[ch][ST_OV_WARN];
    assign any_uv[ch] = st_vout[ch][ST_UV_FAULT] | st_vout[ch][ST_UV_WARN];
    assign any_ton[ch] = st_vout[ch][ST_TON_MAX];
  end

  ////////////////////////////////////////////////////////////////////////////
  // summary status and alert

  always_comb begin
    status_word = 16'h0000;
    status_word[SW_VOUT_BIT] = |{any_ov, any_uv, any_ton}; // R18
    status_word[SW_VIN_BIT] = |st_vin;
    status_word[SW_TON_BIT] = |any_ton;
    status_word[SW_OV_BIT] = |any_ov; // R18
    status_word[SW_UV_BIT] = |any_uv; // R18
    status_word[SW_TEMP_BIT] = |st_temp;
  end

  // open-drain: only ever pulls low, released when all status is clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_alert_line_n_o <= 1'b1;
      host_alert_line_oe_o <= 1'b0;
    end else begin
      host_alert_line_n_o <= ~(|status_word); // R18
      host_alert_line_oe_o <= |status_word; // R18
    end
  end

endmodule : ssl_sequencer

`default_nettype wire

// ===== common/ssl_pkg.sv
// constants, types and register map of the supply sequencing and limits core
//
// Behaviour
// (R1) output target, ceiling, margin, limits and good levels are 16-bit linear-16 volts
// (R2) linear-16 exponent is fixed at minus thirteen, read back as a 5-bit field
// (R3) input start, stop and input limits are 16-bit linear-11 volts
// (R4) the six input thresholds are compared against the input sense measurement
// (R5) temperature limits are 16-bit linear-11 degrees Celsius
// (R6) the four timer settings are 16-bit linear-11 milliseconds
// (R7) turn-on delay precedes converter enable and counts only timebase ticks
// (R8) with trim mode 00b the trim output connects after the ramp time
// (R9) ramp, ramp timeout and turn-off delay use timebase, else internal oscillator
// (R10) ramp timeout bounds the climb to the under-voltage fault threshold
// (R11) threshold reached in time unmasks it, otherwise a ramp timeout fault
// (R12) ramp timeout of zero means no limit
// (R13) after the on request drops, wait turn-off delay then disable
// (R14) turn-on and turn-off delays clamp at 13.1 seconds
// (R15) those delays round to 10us below 655ms and 200us above
// (R16) ramp time and ramp timeout clamp at 655ms, round to 10us
// (R17) timer settings read back exactly as written
// (R18) fast supervisor faults set status bits and pull the alert line low
// (R19) fast supervisor fault response has an optional deglitch period
// (R20) odd channels in current mode ignore output over/under faults and warnings
package ssl_pkg;

  localparam int NUM_CH = 8;
  localparam int PAGED_N = 14;
  localparam int GLOB_N = 10;
  localparam int TIMER_N = 4;

  // command codes of the management port
  localparam logic [7:0] CMD_PAGED_BASE = 8'h20;
  localparam logic [7:0] CMD_GLOB_BASE = 8'h40;
  localparam logic [7:0] CMD_OPERATION = 8'h30;
  localparam logic [7:0] CMD_CHAN_CFG = 8'h31;
  localparam logic [7:0] CMD_STATUS_VOUT = 8'h32;
  localparam logic [7:0] CMD_OUT_MODE = 8'h50;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h51;
  localparam logic [7:0] CMD_STATUS_VIN = 8'h52;
  localparam logic [7:0] CMD_STATUS_TEMP = 8'h53;
  localparam logic [7:0] CMD_CLEAR = 8'h54;

  // paged slots 0..9 are the output levels, then the four timers
  localparam int IDX_TON_DELAY = 10;
  localparam int IDX_TOFF_DELAY = 13;
  // global slots
  localparam int IDX_VIN_ON = 0;
  localparam int IDX_VIN_OFF = 1;
  localparam int IDX_VIN_OV_F = 2;
  localparam int IDX_VIN_OV_W = 3;
  localparam int IDX_VIN_UV_W = 4;
  localparam int IDX_VIN_UV_F = 5;
  localparam int IDX_OT_F = 6;
  localparam int IDX_OT_W = 7;
  localparam int IDX_UT_W = 8;
  localparam int IDX_UT_F = 9;
  // effective timer slots
  localparam int TM_ON = 0;
  localparam int TM_RISE = 1;
  localparam int TM_MAX = 2;
  localparam int TM_OFF = 3;

  localparam logic [15:0] LIMIT_RESET = 16'h0000;
  localparam logic [15:0] OPERATION_RESET = 16'h0000;
  localparam logic [15:0] CHAN_CFG_RESET = 16'h0000;
  localparam logic [15:0] OUT_MODE_VALUE = 16'h0013;

  localparam int OP_ON_BIT = 0;
  localparam int CFG_DAC_LSB = 0;
  localparam int CFG_HIRES_BIT = 2;
  localparam int CFG_DEGLITCH_LSB = 4;

  localparam int ST_OV_FAULT = 7;
  localparam int ST_OV_WARN = 6;
  localparam int ST_UV_WARN = 5;
  localparam int ST_UV_FAULT = 4;
  localparam int ST_TON_MAX = 2;
  localparam int SW_VOUT_BIT = 15;
  localparam int SW_VIN_BIT = 13;
  localparam int SW_TON_BIT = 12;
  localparam int SW_OV_BIT = 5;
  localparam int SW_UV_BIT = 3;
  localparam int SW_TEMP_BIT = 2;

  // timing
  localparam int SYS_CLK_NS = 25;
  localparam int SHARE_CLK_NS = 30;
  localparam int FINE_STEP_US = 10;
  localparam int COARSE_STEP_US = 200;
  localparam int TON_LIMIT_MS = 13100;
  localparam int RISE_LIMIT_MS = 655;
  localparam int TS_VS_NS = 12200;
  localparam int TICK_NS = FINE_STEP_US * 1000;
  localparam int INT_TICK_CYC = TICK_NS / SYS_CLK_NS;
  localparam int SHARE_TICK_CYC = TICK_NS / SHARE_CLK_NS;
  localparam int SHARE_LOSS_CYC = 3 * INT_TICK_CYC;
  localparam int SAMPLE_CYC = TS_VS_NS / SYS_CLK_NS;
  localparam int TICKS_PER_MS = 1000 / FINE_STEP_US;
  localparam int TON_LIMIT_TICKS = TON_LIMIT_MS * TICKS_PER_MS;
  localparam int RISE_LIMIT_TICKS = RISE_LIMIT_MS * TICKS_PER_MS;
  localparam int COARSE_TICKS = COARSE_STEP_US / FINE_STEP_US;
  localparam int TICK_W = 21;

  typedef enum logic [2:0] {
    CH_OFF = 3'h0,
    CH_ON_WAIT = 3'h1,
    CH_RAMP = 3'h2,
    CH_ON = 3'h3,
    CH_OFF_WAIT = 3'h4
  } ssl_ch_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [2:0] page;
    logic [7:0] cmd;
    logic [15:0] wdata;
  } ssl_reg_req_s;

  typedef struct packed {
    logic ov_fault;
    logic ov_warn;
    logic uv_warn;
    logic uv_fault;
  } ssl_fast_sup_s;

endpackage : ssl_pkg

// ===== verification/ssl_sequencer_chk.sv
// assertion checker of the sequencing and limits core
`timescale 1ns/1ps
`default_nettype none
module ssl_sequencer_chk import ssl_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire ssl_reg_req_s reg_req_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic reg_ack_o,
  input wire logic [NUM_CH-1:0] channel_on_request_pin_i,
  input wire ssl_fast_sup_s [NUM_CH-1:0] fast_sup_i,
  input wire logic [NUM_CH-1:0] converter_enable_o,
  input wire logic [NUM_CH-1:0] dac_connect_o,
  input wire logic host_alert_line_n_o,
  input wire logic host_alert_line_oe_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  logic [11:0] ov_run;
  wire logic req = reg_req_i.wr || reg_req_i.rd;
  ////////////////////////////////////////////////////////////////////////////
  // run longer than the slowest deglitch, so no config can excuse it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ov_run <= 12'h000;
    end else if (!fast_sup_i[0].ov_fault) begin
      ov_run <= 12'h000;
    end else if (ov_run != 12'hFFF) begin
      ov_run <= ov_run + 12'h001;
    end
  end
  AST_ACK: assert property (req |=> reg_ack_o) else $error("ack missing");
  AST_NO_ACK: assert property (!req |=> !reg_ack_o) else $error("ack unasked");
  AST_IDLE_DATA: assert property (!reg_ack_o |-> reg_rdata_o == 16'h0000)
    else $error("read data outside ack");
  AST_OUT_MODE: assert property (
    reg_req_i.rd && reg_req_i.cmd == CMD_OUT_MODE |=> reg_rdata_o == OUT_MODE_VALUE)
    else $error("output mode value wrong");
  AST_ALERT_OE: assert property (host_alert_line_oe_o == !host_alert_line_n_o)
    else $error("alert enable and value disagree");
  AST_OV_ALERT: assert property (
    ov_run == 12'hDAC |-> !host_alert_line_n_o) else $error("fault left alert idle");
  AST_EN_CAUSE: assert property (
    $rose(converter_enable_o[0]) |-> $past(channel_on_request_pin_i[0], 3))
    else $error("enable without request");
  AST_DAC_AFTER_EN: assert property (
    $rose(dac_connect_o[0]) |-> $past(converter_enable_o[0])) else $error("trim before enable");
  AST_OFF_DELAYED: assert property (
    $fell(channel_on_request_pin_i[0]) && converter_enable_o[0] |=> converter_enable_o[0])
    else $error("enable dropped at once");
  COV_EN: cover property ($rose(converter_enable_o[0]));
  COV_DAC: cover property ($rose(dac_connect_o[0]));
  COV_ALERT: cover property ($fell(host_alert_line_n_o));
endmodule : ssl_sequencer_chk
bind ssl_sequencer ssl_sequencer_chk i_ssl_sequencer_chk (.*);
`default_nettype wire

// ===== verification/ssl_supply_model.sv
// converter model: output below the under-voltage level until ramped
`timescale 1ns/1ps
`default_nettype none
module ssl_supply_model import ssl_pkg::*; #(parameter int RAMP_CYC = 50) (
  input wire logic clk_i,
  input wire logic [NUM_CH-1:0] enable_i,
  input wire logic [NUM_CH-1:0] stuck_i,
  input wire logic [NUM_CH-1:0] over_i,
  output var ssl_fast_sup_s [NUM_CH-1:0] sup_o
);
  int cnt [NUM_CH];
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < NUM_CH; c++) begin
      cnt[c] <= !enable_i[c] ? 0 : (cnt[c] < RAMP_CYC ? cnt[c] + 1 : cnt[c]);
    end
  end
  // stuck channels never climb, to provoke the ramp timeout
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      sup_o[c] = '{over_i[c], 1'b0, 1'b0, stuck_i[c] || cnt[c] < RAMP_CYC};
    end
  end
endmodule : ssl_supply_model
`default_nettype wire

// ===== verification/ssl_sequencer_bench.sv
// self-checking bench of the sequencing and limits core
`timescale 1ns/1ps
`default_nettype none
module ssl_sequencer_bench import ssl_pkg::*; ;
  logic sys_clk_i = 1'b0, rst_i = 1'b1, share_clk = 1'b0, sh_run = 1'b0;
  ssl_reg_req_s reg_req_i = '0;
  logic [15:0] rdata, q, vin = '0;
  logic ack, alert_n, alert_oe, present;
  logic [NUM_CH-1:0] pin = '0, stuck = '0, over = '0, en, dac;
  ssl_fast_sup_s [NUM_CH-1:0] sup;
  wire logic [15:0] obs = {dac, en};
  wire logic alert_w = alert_oe ? alert_n : 1'b1;
  int n_mismatch = 0, compares = 0, cycles = 0, k;
  always #12.5 sys_clk_i = ~sys_clk_i;
  // timebase stands still while stopped
  always #15 share_clk = sh_run ? ~share_clk : 1'b0;
  ssl_sequencer i_ssl_sequencer (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .share_clk_i(share_clk),
    .reg_req_i(reg_req_i), .reg_rdata_o(rdata), .reg_ack_o(ack),
    .channel_on_request_pin_i(pin), .fast_sup_i(sup), .input_sense_pin_i(vin),
    .die_temp_i(16'h0000), .converter_enable_o(en), .dac_connect_o(dac),
    .host_alert_line_n_o(alert_n), .host_alert_line_oe_o(alert_oe), .share_present_o(present));
  ssl_supply_model i_ssl_supply_model (.clk_i(sys_clk_i), .enable_i(en), .stuck_i(stuck),
    .over_i(over), .sup_o(sup));
  ////////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : cyc
  task rw(input logic w, input logic [2:0] p, input logic [7:0] c, input logic [15:0] d);
    int j;
    reg_req_i <= '{w, !w, p, c, d};
    cyc(1);
    reg_req_i <= '0;
    for (j = 0; j < 3 && ack !== 1'b1; j++) cyc(1);
    q = rdata;
    chk(16'(ack), 16'h0001);
    cyc(1);
  endtask : rw
  task wt(input int s, input logic v, input int hi, output int n);
    for (n = 0; n < hi && obs[s] !== v; n++) cyc(1);
  endtask : wt
  function logic [7:0] cm(input int i);
    return i < 14 ? CMD_PAGED_BASE + 8'(i) : CMD_GLOB_BASE + 8'(i - 14);
  endfunction : cm
  function logic [15:0] pat(input int i);
    return 16'hA5C3 ^ 16'(i * 4369);
  endfunction : pat
  function logic [15:0] win(input int n);
    return 16'(n > 1900 && n < 3500);
  endfunction : win
  ////////////////////////////////////////////////////////////////////////////
  task t_regs;
    for (k = 0; k < 24; k++) rw(1'b1, 3'h7, cm(k), pat(k));
    for (k = 0; k < 24; k++) begin
      rw(1'b0, 3'h7, cm(k), 16'h0000);
      chk(q, pat(k));
    end
    // wide-open limits so no input or temperature fault disturbs later checks
    for (k = 14; k < 24; k++)
      rw(1'b1, 3'h0, cm(k), (k - 14) inside {2, 3, 6, 7} ? 16'h7BFF : 16'h0000);
    rw(1'b1, 3'h0, CMD_OUT_MODE, 16'hFFFF);
    rw(1'b0, 3'h0, CMD_OUT_MODE, 16'h0000);
    chk(q, 16'h0013);
    rw(1'b0, 3'h0, 8'h7F, 16'h0000);
    chk(q, 16'h0000);
    rw(1'b1, 3'h0, CMD_CLEAR, 16'h0000);
  endtask : t_regs
  task t_share;
    rw(1'b1, 3'h0, CMD_OPERATION, 16'h0001);
    for (k = 10; k < 14; k++) rw(1'b1, 3'h0, cm(k), 16'hE001);
    pin[0] <= 1'b1;
    wt(0, 1'b1, 3000, k);
    chk(16'(k == 3000), 16'h0001);
    sh_run = 1'b1;
    wt(0, 1'b1, 4000, k);
    chk(win(k), 16'h0001);
    chk(16'(present), 16'h0001);
    wt(8, 1'b1, 4000, k);
    chk(win(k), 16'h0001);
    pin[0] <= 1'b0;
    wt(0, 1'b0, 4000, k);
    chk(win(k), 16'h0001);
    rw(1'b0, 3'h0, CMD_STATUS_VOUT, 16'h0000);
    chk(q & 16'h0004, 16'h0000);
  endtask : t_share
  task t_ramp;
    for (k = 1; k < 3; k++) rw(1'b1, 3'(k), CMD_OPERATION, 16'h0001);
    rw(1'b1, 3'h1, cm(12), 16'hE001);
    stuck <= 8'h06;
    pin <= 8'h06;
    cyc(4000);
    rw(1'b0, 3'h1, CMD_STATUS_VOUT, 16'h0000);
    chk(q & 16'h0004, 16'h0004);
    rw(1'b0, 3'h1, CMD_STATUS_WORD, 16'h0000);
    chk(q & 16'h1000, 16'h1000);
    chk(16'(alert_w), 16'h0000);
    rw(1'b0, 3'h2, CMD_STATUS_VOUT, 16'h0000);
    chk(q & 16'h0004, 16'h0000);
    stuck <= '0;
    pin <= '0;
    cyc(10);
    for (k = 1; k < 3; k++) rw(1'b1, 3'(k), CMD_CLEAR, 16'h0000);
    cyc(4);
    chk(16'(alert_w), 16'h0001);
  endtask : t_ramp
  task t_fast;
    {vin, over[0]} <= {16'h07FF, 1'b1};
    cyc(8);
    rw(1'b0, 3'h0, CMD_STATUS_VIN, 16'h0000);
    chk(q & 16'h0030, 16'h0030);
    rw(1'b0, 3'h0, CMD_STATUS_VOUT, 16'h0000);
    chk(q & 16'h0080, 16'h0080);
    chk(16'(alert_w), 16'h0000);
    {vin, over[0]} <= 17'h00000;
    cyc(4);
    rw(1'b1, 3'h0, CMD_CLEAR, 16'h0000);
    rw(1'b1, 3'h1, CMD_CHAN_CFG, 16'h0004);
    rw(1'b1, 3'h0, CMD_CHAN_CFG, 16'h0070);
    over <= 8'h03;
    cyc(200);
    over[0] <= 1'b0;
    cyc(8);
    chk(16'(alert_w), 16'h0001);
    over[0] <= 1'b1;
    cyc(2800);
    chk(16'(alert_w), 16'h0001);
    cyc(800);
    chk(16'(alert_w), 16'h0000);
    rw(1'b0, 3'h1, CMD_STATUS_VOUT, 16'h0000);
    chk(q & 16'h00C0, 16'h0000);
    over <= '0;
  endtask : t_fast
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial begin
    cyc(8);
    rst_i <= 1'b0;
    cyc(2);
    t_regs();
    t_share();
    t_ramp();
    t_fast();
    give_verdict();
  end
endmodule : ssl_sequencer_bench
`default_nettype wire
